// ===== hdl/ist_pkg.sv
package ist_pkg;

    // Register byte offsets
    localparam logic [7:0] INTC0_OFF  = 8'h00;
    localparam logic [7:0] INTC1_OFF  = 8'h04;
    localparam logic [7:0] MFI0_OFF   = 8'h08;
    localparam logic [7:0] MFI1_OFF   = 8'h0c;
    localparam logic [7:0] PSC_OFF    = 8'h10;
    localparam logic [7:0] TB0C_OFF   = 8'h14;
    localparam logic [7:0] TB1C_OFF   = 8'h18;
    localparam logic [7:0] EDGE_OFF   = 8'h1c;
    localparam logic [7:0] STAT_OFF   = 8'h20;

    // Control bit positions (control register 0)
    localparam int GIE_BIT   = 0;
    localparam int EXTE_BIT  = 1;
    localparam int MF0E_BIT  = 2;
    localparam int MF1E_BIT  = 3;
    localparam int EXTF_BIT  = 4;
    localparam int MF0F_BIT  = 5;
    localparam int MF1F_BIT  = 6;
    // Control register 1
    localparam int TB0E_BIT  = 0;
    localparam int TB1E_BIT  = 1;
    localparam int CONVE_BIT = 3;
    localparam int TB0F_BIT  = 4;
    localparam int TB1F_BIT  = 5;
    localparam int CONVF_BIT = 7;
    // Timer module source registers
    localparam int PE_BIT    = 0;
    localparam int AE_BIT    = 1;
    localparam int PF_BIT    = 4;
    localparam int AF_BIT    = 5;
    // Prescaler and tick channel
    localparam int PSC_ON_BIT = 2;
    localparam int TB_ON_BIT  = 7;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] DIV4_LAST = 2'h3;
    localparam int         TB_MIN_EXP = 8;

    // Edge select codes
    typedef enum logic [1:0] {
        IST_EDGE_OFF  = 2'h0,
        IST_EDGE_RISE = 2'h1,
        IST_EDGE_FALL = 2'h2,
        IST_EDGE_BOTH = 2'h3
    } ist_edge_t;

    // Vector numbers, in priority order
    typedef enum logic [2:0] {
        IST_VEC_EXT  = 3'h0,
        IST_VEC_MF0  = 3'h1,
        IST_VEC_MF1  = 3'h2,
        IST_VEC_CONV = 3'h3,
        IST_VEC_TB0  = 3'h4,
        IST_VEC_TB1  = 3'h5
    } ist_vec_t;

    // Events from peripherals
    typedef struct packed {
        logic       conv_done;
        logic [1:0] tm_a_match;
        logic [1:0] tm_p_match;
    } ist_events_t;

    // Request to the core
    typedef struct packed {
        logic     valid;
        ist_vec_t vector;
    } ist_req_t;

endpackage : ist_pkg

// ===== hdl/ist_irq.sv
`timescale 1ns/1ps
module ist_irq (
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Pins and clocks
    input  wire logic               ext_irq_pin,
    input  wire logic               sub_clk,
    output logic                    ext_pull_keep,
    // Peripheral events
    input  wire ist_pkg::ist_events_t events,
    // Core side
    input  wire logic               stack_full,
    input  wire logic               irq_ack,
    input  wire logic               global_set,
    output ist_pkg::ist_req_t       irq_req,
    output logic                    wake_up
);

    logic [7:0]        ctl0_reg;
    logic [7:0]        ctl0_next;
    logic [7:0]        ctl1_reg;
    logic [7:0]        ctl1_next;
    logic [7:0]        mfi0_reg;
    logic [7:0]        mfi0_next;
    logic [7:0]        mfi1_reg;
    logic [7:0]        mfi1_next;
    logic [7:0]        psc_reg;
    logic [7:0]        psc_next;
    logic [7:0]        tb0_reg;
    logic [7:0]        tb0_next;
    logic [7:0]        tb1_reg;
    logic [7:0]        tb1_next;
    logic [1:0]        edge_reg;
    logic [1:0]        edge_next;
    logic [2:0]        pin_reg;
    logic [2:0]        pin_next;
    logic [2:0]        sub_reg;
    logic [2:0]        sub_next;
    logic [1:0]        div4_reg;
    logic [1:0]        div4_next;
    logic [14:0]       pcnt_reg;
    logic [14:0]       pcnt_next;
    logic [9:0]        flags_old_reg;
    logic [9:0]        flags_old_next;
    logic [31:0]       rd_reg;
    logic [31:0]       rd_next;
    logic              wake_reg;
    logic              wake_next;
    logic              wr;
    logic              rd;
    logic              mapped;
    logic              rise;
    logic              fall;
    logic              psc_tick;
    logic              sub_rise;
    logic              ext_evt;
    logic [1:0]        tb_ovf;
    logic [5:0]        pend;
    logic [9:0]        flags_now;
    ist_pkg::ist_req_t req_c;

    // APB access decode
    always_comb begin
        wr = psel & penable & pwrite;
        rd = psel & ~penable & ~pwrite;
    end

    // Pin and sub-clock synchronisers, edge taken after second stage
    always_comb begin
        pin_next = {pin_reg[1:0], ext_irq_pin};
        sub_next = {sub_reg[1:0], sub_clk};
    end
    always_comb begin
        rise     = pin_reg[1] & ~pin_reg[2];
        fall     = ~pin_reg[1] & pin_reg[2];
        sub_rise = sub_reg[1] & ~sub_reg[2];
    end

    // Prescaler clock source and gate
    always_comb begin
        if (psc_reg[1])
            psc_tick = sub_rise;
        else if (psc_reg[0])
            psc_tick = (div4_reg == ist_pkg::DIV4_LAST);
        else
            psc_tick = 1'b1;
        psc_tick = psc_tick & psc_reg[ist_pkg::PSC_ON_BIT];
    end

    // Divide-by-four phase and shared prescaler count
    always_comb begin
        div4_next = div4_reg + 2'h1;
        pcnt_next = pcnt_reg;
        if (!psc_reg[ist_pkg::PSC_ON_BIT])
            div4_next = div4_reg;
        if (psc_tick)
            pcnt_next = pcnt_reg + 15'h0001;
    end

    // Divider overflow per tick channel
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_tb
            logic [7:0] c;
            logic [3:0] e;
            assign c = (g == 0) ? tb0_reg : tb1_reg;
            assign e = 4'(ist_pkg::TB_MIN_EXP) + {1'b0, c[2:0]};
            assign tb_ovf[g] = psc_tick & c[ist_pkg::TB_ON_BIT]
                               & (pcnt_reg[e - 4'h1 -: 1] == 1'b1)
                               & ((pcnt_reg & ((15'h0001 << (e - 4'h1)) - 15'h0001))
                                  == ((15'h0001 << (e - 4'h1)) - 15'h0001));
        end
    endgenerate

    // Pending enabled requests and priority
    always_comb begin
        pend[0] = ctl0_reg[ist_pkg::EXTF_BIT] & ctl0_reg[ist_pkg::EXTE_BIT];
        pend[1] = ctl0_reg[ist_pkg::MF0F_BIT] & ctl0_reg[ist_pkg::MF0E_BIT];
        pend[2] = ctl0_reg[ist_pkg::MF1F_BIT] & ctl0_reg[ist_pkg::MF1E_BIT];
        pend[3] = ctl1_reg[ist_pkg::CONVF_BIT] & ctl1_reg[ist_pkg::CONVE_BIT];
        pend[4] = ctl1_reg[ist_pkg::TB0F_BIT] & ctl1_reg[ist_pkg::TB0E_BIT];
        pend[5] = ctl1_reg[ist_pkg::TB1F_BIT] & ctl1_reg[ist_pkg::TB1E_BIT];
    end

    // Request valid and vector
    always_comb begin
        req_c.valid  = |pend & ctl0_reg[ist_pkg::GIE_BIT] & ~stack_full;
        req_c.vector = ist_pkg::IST_VEC_TB1;
        if (pend[0])
            req_c.vector = ist_pkg::IST_VEC_EXT;
        else if (pend[1])
            req_c.vector = ist_pkg::IST_VEC_MF0;
        else if (pend[2])
            req_c.vector = ist_pkg::IST_VEC_MF1;
        else if (pend[3])
            req_c.vector = ist_pkg::IST_VEC_CONV;
        else if (pend[4])
            req_c.vector = ist_pkg::IST_VEC_TB0;
    end
    assign irq_req = req_c;

    // Selected pin edge
    always_comb begin
        ext_evt = 1'b0;
        unique case (ist_pkg::ist_edge_t'(edge_reg))
            ist_pkg::IST_EDGE_RISE: ext_evt = rise;
            ist_pkg::IST_EDGE_FALL: ext_evt = fall;
            ist_pkg::IST_EDGE_BOTH: ext_evt = rise | fall;
            ist_pkg::IST_EDGE_OFF:  ext_evt = 1'b0;
        endcase
    end

    // Register next values: software writes, then hardware clears, then sets
    always_comb begin
        logic       srv;
        logic [1:0] mask;
        srv = irq_ack & req_c.valid;
        mask = 2'h0;
        ctl0_next = ctl0_reg;
        ctl1_next = ctl1_reg;
        mfi0_next = mfi0_reg;
        mfi1_next = mfi1_reg;
        psc_next  = psc_reg;
        tb0_next  = tb0_reg;
        tb1_next  = tb1_reg;
        edge_next = edge_reg;
        if (wr) begin
            unique case (paddr)
                ist_pkg::INTC0_OFF: ctl0_next = {1'b0, pwdata[6:0]};
                ist_pkg::INTC1_OFF: ctl1_next = pwdata[7:0] & 8'hbb;
                ist_pkg::MFI0_OFF:  mfi0_next = pwdata[7:0] & 8'h33;
                ist_pkg::MFI1_OFF:  mfi1_next = pwdata[7:0] & 8'h33;
                ist_pkg::PSC_OFF:   psc_next  = pwdata[7:0] & 8'h07;
                ist_pkg::TB0C_OFF:  tb0_next  = pwdata[7:0] & 8'h87;
                ist_pkg::TB1C_OFF:  tb1_next  = pwdata[7:0] & 8'h87;
                ist_pkg::EDGE_OFF:  edge_next = pwdata[1:0];
                default: ;
            endcase
        end
        if (srv) begin
            ctl0_next[ist_pkg::GIE_BIT] = 1'b0;
            unique case (req_c.vector)
                ist_pkg::IST_VEC_EXT:  ctl0_next[ist_pkg::EXTF_BIT] = 1'b0;
                ist_pkg::IST_VEC_MF0:  ctl0_next[ist_pkg::MF0F_BIT] = 1'b0;
                ist_pkg::IST_VEC_MF1:  ctl0_next[ist_pkg::MF1F_BIT] = 1'b0;
                ist_pkg::IST_VEC_CONV: ctl1_next[ist_pkg::CONVF_BIT] = 1'b0;
                ist_pkg::IST_VEC_TB0:  ctl1_next[ist_pkg::TB0F_BIT] = 1'b0;
                default:               ctl1_next[ist_pkg::TB1F_BIT] = 1'b0;
            endcase
        end
        if (global_set)
            ctl0_next[ist_pkg::GIE_BIT] = 1'b1;
        if (ext_evt)
            ctl0_next[ist_pkg::EXTF_BIT] = 1'b1;
        // Timer sources: P and A match flags
        if (events.tm_p_match[0]) mfi0_next[ist_pkg::PF_BIT] = 1'b1;
        if (events.tm_a_match[0]) mfi0_next[ist_pkg::AF_BIT] = 1'b1;
        if (events.tm_p_match[1]) mfi1_next[ist_pkg::PF_BIT] = 1'b1;
        if (events.tm_a_match[1]) mfi1_next[ist_pkg::AF_BIT] = 1'b1;
        // Merged flag sets on a newly set enabled source
        mask[0] = (mfi0_next[ist_pkg::PF_BIT] & ~mfi0_reg[ist_pkg::PF_BIT] & mfi0_reg[ist_pkg::PE_BIT])
                | (mfi0_next[ist_pkg::AF_BIT] & ~mfi0_reg[ist_pkg::AF_BIT] & mfi0_reg[ist_pkg::AE_BIT]);
        mask[1] = (mfi1_next[ist_pkg::PF_BIT] & ~mfi1_reg[ist_pkg::PF_BIT] & mfi1_reg[ist_pkg::PE_BIT])
                | (mfi1_next[ist_pkg::AF_BIT] & ~mfi1_reg[ist_pkg::AF_BIT] & mfi1_reg[ist_pkg::AE_BIT]);
        if (mask[0]) ctl0_next[ist_pkg::MF0F_BIT] = 1'b1;
        if (mask[1]) ctl0_next[ist_pkg::MF1F_BIT] = 1'b1;
        if (events.conv_done) ctl1_next[ist_pkg::CONVF_BIT] = 1'b1;
        if (tb_ovf[0]) ctl1_next[ist_pkg::TB0F_BIT] = 1'b1;
        if (tb_ovf[1]) ctl1_next[ist_pkg::TB1F_BIT] = 1'b1;
    end

    // Read data, prepared in setup phase
    always_comb begin
        rd_next = rd_reg;
        if (rd) begin
            unique case (paddr)
                ist_pkg::INTC0_OFF: rd_next = {24'h000000, ctl0_reg};
                ist_pkg::INTC1_OFF: rd_next = {24'h000000, ctl1_reg};
                ist_pkg::MFI0_OFF:  rd_next = {24'h000000, mfi0_reg};
                ist_pkg::MFI1_OFF:  rd_next = {24'h000000, mfi1_reg};
                ist_pkg::PSC_OFF:   rd_next = {24'h000000, psc_reg};
                ist_pkg::TB0C_OFF:  rd_next = {24'h000000, tb0_reg};
                ist_pkg::TB1C_OFF:  rd_next = {24'h000000, tb1_reg};
                ist_pkg::EDGE_OFF:  rd_next = {30'h0, edge_reg};
                ist_pkg::STAT_OFF:  rd_next = {26'h0, pin_reg[2], req_c.valid, 1'b0, req_c.vector};
                default:            rd_next = 32'h00000000;
            endcase
        end
    end

    always_comb begin
        mapped = (paddr <= ist_pkg::STAT_OFF) & (paddr[1:0] == 2'h0);
        flags_now = {mfi1_reg[ist_pkg::AF_BIT], mfi1_reg[ist_pkg::PF_BIT],
                     mfi0_reg[ist_pkg::AF_BIT], mfi0_reg[ist_pkg::PF_BIT],
                     ctl1_reg[ist_pkg::TB1F_BIT], ctl1_reg[ist_pkg::TB0F_BIT],
                     ctl1_reg[ist_pkg::CONVF_BIT], ctl0_reg[ist_pkg::MF1F_BIT],
                     ctl0_reg[ist_pkg::MF0F_BIT], ctl0_reg[ist_pkg::EXTF_BIT]};
        flags_old_next = flags_now;
        wake_next      = |(flags_now & ~flags_old_reg);
    end
    assign pready        = 1'b1;
    assign pslverr       = psel & penable & ~mapped;
    assign prdata        = rd_reg;
    assign wake_up       = wake_reg;
    assign ext_pull_keep = 1'b1;

    // Control and source registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl0_reg      <= ist_pkg::REG_RESET;
            ctl1_reg      <= ist_pkg::REG_RESET;
            mfi0_reg      <= ist_pkg::REG_RESET;
            mfi1_reg      <= ist_pkg::REG_RESET;
            psc_reg       <= ist_pkg::REG_RESET;
            tb0_reg       <= ist_pkg::REG_RESET;
            tb1_reg       <= ist_pkg::REG_RESET;
            edge_reg      <= 2'h0;
        end else begin
            ctl0_reg      <= ctl0_next;
            ctl1_reg      <= ctl1_next;
            mfi0_reg      <= mfi0_next;
            mfi1_reg      <= mfi1_next;
            psc_reg       <= psc_next;
            tb0_reg       <= tb0_next;
            tb1_reg       <= tb1_next;
            edge_reg      <= edge_next;
        end
    end

    // Pin and sub-clock synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_reg       <= 3'h0;
            sub_reg       <= 3'h0;
        end else begin
            pin_reg       <= pin_next;
            sub_reg       <= sub_next;
        end
    end

    // Prescaler state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div4_reg      <= 2'h0;
            pcnt_reg      <= 15'h0000;
        end else begin
            div4_reg      <= div4_next;
            pcnt_reg      <= pcnt_next;
        end
    end

    // Read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_reg        <= 32'h00000000;
        end else begin
            rd_reg        <= rd_next;
        end
    end

    // Flag history and wake-up pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_old_reg <= 10'h000;
            wake_reg      <= 1'b0;
        end else begin
            flags_old_reg <= flags_old_next;
            wake_reg      <= wake_next;
        end
    end

endmodule : ist_irq

// ===== tb/ist_irq_monitor.sv
`timescale 1ns/1ps
module ist_irq_monitor (
    // Clock, reset and APB
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [7:0]           paddr,
    input wire logic [31:0]          pwdata,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    // Pins, events and core side
    input wire logic                 ext_irq_pin,
    input wire logic                 sub_clk,
    input wire logic                 ext_pull_keep,
    input wire ist_pkg::ist_events_t events,
    input wire logic                 stack_full,
    input wire logic                 irq_ack,
    input wire logic                 global_set,
    input wire ist_pkg::ist_req_t    irq_req,
    input wire logic                 wake_up
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence ack_s;
        irq_ack && irq_req.valid && !global_set && !(psel && penable && pwrite);
    endsequence
    sequence wr_s;
        psel && penable && pwrite;
    endsequence
    ready_high_a: assert property (pready) else $error("pready low");
    err_phase_a: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
    err_unmapped_a: assert property (psel && penable && (paddr > 8'h20 || paddr[1:0] != 2'h0) |-> pslverr)
        else $error("no pslverr on unmapped");
    err_mapped_a: assert property (psel && penable && paddr <= 8'h20 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("pslverr on mapped");
    err_read_a: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    pull_keep_a: assert property (ext_pull_keep) else $error("pull-high dropped");
    ack_block_a: assert property (ack_s |=> !irq_req.valid) else $error("request after service");
    stack_block_a: assert property (stack_full |-> !irq_req.valid) else $error("request with stack full");
    valid_hold_a: assert property ($fell(irq_req.valid) |-> $past(irq_ack) || stack_full || $past(psel && penable && pwrite))
        else $error("request lost");
    write_keep_a: assert property (wr_s ##1 !irq_ack [*2] |-> !$fell(irq_req.valid) || $past(psel && penable && pwrite) || stack_full)
        else $error("request lost after write");
    vec_range_a: assert property (irq_req.valid |-> irq_req.vector <= ist_pkg::IST_VEC_TB1)
        else $error("vector out of range");
endmodule : ist_irq_monitor
bind ist_irq ist_irq_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ext_irq_pin, .sub_clk, .ext_pull_keep, .events, .stack_full, .irq_ack, .global_set, .irq_req, .wake_up);

// ===== tb/ist_core_model.sv
`timescale 1ns/1ps
module ist_core_model (
    // Clock and reset
    input wire logic               pclk,
    input wire logic               presetn,
    // Request and behaviour
    input wire ist_pkg::ist_req_t  irq_req,
    input wire logic               slow,
    input wire logic               ret_en,
    // Answers
    output logic                   irq_ack,
    output logic                   global_set,
    output ist_pkg::ist_vec_t      last_vec,
    output logic [7:0]             taken
);
    logic [1:0] wait_cnt;
    logic [1:0] ret_cnt;
    // Takes a vector, then returns with enable when asked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ack <= 1'b0;
            global_set <= 1'b0;
            last_vec <= ist_pkg::IST_VEC_EXT;
            taken <= 8'h00;
            wait_cnt <= 2'h0;
            ret_cnt <= 2'h0;
        end else begin
            irq_ack <= 1'b0;
            global_set <= 1'b0;
            if (ret_cnt != 2'h0) begin
                ret_cnt <= ret_cnt - 2'h1;
                global_set <= (ret_cnt == 2'h1);
            end else if (irq_req.valid && !irq_ack) begin
                if (wait_cnt == (slow ? 2'h3 : 2'h0)) begin
                    irq_ack <= 1'b1;
                    last_vec <= irq_req.vector;
                    taken <= taken + 8'h01;
                    wait_cnt <= 2'h0;
                    ret_cnt <= ret_en ? 2'h3 : 2'h0;
                end else begin
                    wait_cnt <= wait_cnt + 2'h1;
                end
            end
        end
    end
endmodule : ist_core_model

// ===== tb/irq_sources_timebase_bench.sv
`timescale 1ns/1ps
module irq_sources_timebase_bench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pin = 0, sub_clk = 0, stack_full = 0;
    logic slow = 0, ret_en = 0, pready, pslverr, pull, irq_ack, global_set, wake_up;
    logic [7:0] paddr = 8'h00, taken, t0;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    ist_pkg::ist_events_t ev = '0;
    ist_pkg::ist_req_t req;
    ist_pkg::ist_vec_t vec;
    int fails = 0, checked = 0, cyc = 0, wakes = 0, m, u, tm, seed = 32'h83eb5c35;
    ist_irq dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .ext_irq_pin(pin), .sub_clk, .ext_pull_keep(pull), .events(ev), .stack_full, .irq_ack, .global_set,
        .irq_req(req), .wake_up);
    ist_core_model core (.pclk, .presetn, .irq_req(req), .slow, .ret_en, .irq_ack, .global_set,
        .last_vec(vec), .taken);
    always #20 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        sub_clk <= (cyc % 6) < 3;
        if (wake_up === 1'b1) wakes++;
        if (cyc > 60000) begin fails++; wrap_up(); end
    end
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin fails++; $display("[FAIL] %s expected %h seen %h", n, e, s); end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk); psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk); penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata; psel <= 0; penable <= 0;
    endtask : apb
    task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(0, a, 0); chk(n, rv, e);
    endtask : rdc
    task take();
        t0 = taken;
        while (taken === t0) begin @(posedge pclk); #1; end
    endtask : take
    task pulse(input ist_pkg::ist_events_t e);
        @(posedge pclk) ev <= e; @(posedge pclk) ev <= '0;
    endtask : pulse
    function logic hit(input int md, input int up);
        hit = (md == 3) || (md == 1 && up == 1) || (md == 2 && up == 0);
    endfunction : hit
    function int per(input int src, input int sel);
        per = (src == 0 ? 1 : src == 1 ? 4 : 6) << (8 + sel);
    endfunction : per
    task wrap_up();
        $display("checks %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (2) @(posedge pclk); presetn <= 1;
        for (m = 0; m < 9; m++)
            rdc("reset value", 8'(m * 4), m == 8 ? 32'(ist_pkg::IST_VEC_TB1) : 32'h0);
        rdc("unmapped", 8'h24, 0);
        m = $random(seed); apb(1, 8'h14, m); rdc("tick ctl", 8'h14, m & 8'h87);
        m = $random(seed); apb(1, 8'h10, m); rdc("prescaler", 8'h10, m & 8'h07);
        apb(1, 8'h10, 0);
        $display("registers done");
        for (m = 0; m < 4; m++) for (u = 0; u < 2; u++) begin
            apb(1, 8'h1c, m); pin <= !u; repeat (5) @(posedge pclk);
            apb(1, 8'h00, 0); pin <= u; repeat (5) @(posedge pclk);
            rdc("edge flag", 8'h00, 32'(hit(m, u)) << 4);
        end
        chk("wake", wakes != 0, 1);
        apb(1, 8'h1c, 1); pin <= 0; repeat (5) @(posedge pclk); apb(1, 8'h00, 0);
        stack_full <= 1; apb(1, 8'h00, 8'h03); t0 = taken; pin <= 1; repeat (10) @(posedge pclk);
        chk("stack full", taken, t0);
        stack_full <= 0; slow <= 1; take(); chk("ext vec", vec, ist_pkg::IST_VEC_EXT);
        rdc("ext serviced", 8'h00, 8'h02);
        apb(1, 8'h1c, 0); $display("external done");
        for (m = 0; m < 2; m++) begin
            apb(1, 8'h08 + 8'(m * 4), m + 1); apb(1, 8'h00, 8'h01 | (8'h04 << m));
            pulse(m ? 5'b01000 : 5'b00001); take();
            chk("mf vec", vec, m + 1);
            rdc("source kept", 8'h08 + 8'(m * 4), (m + 1) * 8'h11);
            rdc("mf cleared", 8'h00, 8'h04 << m);
            apb(1, 8'h08 + 8'(m * 4), 0);
        end
        apb(1, 8'h04, 8'h08); apb(1, 8'h00, 8'h01); pulse(5'b10000); take();
        chk("conv vec", vec, ist_pkg::IST_VEC_CONV);
        rdc("conv cleared", 8'h04, 8'h08);
        $display("sources done");
        ret_en <= 1; apb(1, 8'h04, 8'hbb); apb(1, 8'h00, 8'h7f);
        for (m = 0; m < 6; m++) begin take(); chk("priority", vec, m); end
        ret_en <= 0; slow <= 0; apb(1, 8'h00, 0); apb(1, 8'h04, 0);
        apb(1, 8'h10, 0); apb(1, 8'h14, 8'h80); apb(1, 8'h04, 8'h01); apb(1, 8'h00, 8'h01);
        t0 = taken; repeat (600) @(posedge pclk); chk("prescaler off", taken, t0);
        ret_en <= 1;
        for (m = 0; m < 3; m++) begin
            u = $random(seed) & 1;
            apb(1, 8'h10, 4 | (m == 2 ? 2 + ($random(seed) & 1) : m)); apb(1, 8'h14, 8'h80 | u);
            apb(1, 8'h00, 8'h01); take(); take(); tm = cyc; take();
            chk("tick period", cyc - tm, per(m, u));
        end
        $display("time base done");
        wrap_up();
    end
endmodule : irq_sources_timebase_bench
